// ### hw/apc_pkg.sv
// What this block does
// - low pin register: channels 0 to 7
// - mid pin register: channels 8 to 15
// - high pin register: channels 16 to 23
// - bit set releases pin from port control
// - disabled in reset or channel all ones
// - idle, lowest power, between conversions
// - 10-bit: round 11 bits, split high/low
// - 8-bit: round 9 bits, low register only
// - result write sets done flag, optional irq
// - compare enable gates result update, all modes
// - four clock sources, bus clock after reset
// - halved source plus divider reaches 16
// - async clock runs through wait and stop
// - divider of 1, 2, 4 or 8
// - divide codes 00 to 11 map 1..8
// - source codes: bus, half, alternate, async
// - mode codes: 00 8-bit, 10 10-bit
// - 10-bit mode only: high read blocks results until low read
package apc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CMPCTL  = 8'h04;
   localparam logic [7:0] OFS_RES_HI  = 8'h08;
   localparam logic [7:0] OFS_RES_LO  = 8'h0c;
   localparam logic [7:0] OFS_CMP_HI  = 8'h10;
   localparam logic [7:0] OFS_CMP_LO  = 8'h14;
   localparam logic [7:0] OFS_CFG     = 8'h18;
   localparam logic [7:0] OFS_PIN_LO  = 8'h1c;
   localparam logic [7:0] OFS_PIN_MID = 8'h20;
   localparam logic [7:0] OFS_PIN_HI  = 8'h24;
   // field positions
   localparam int BIT_DONE    = 7;
   localparam int BIT_IRQ_EN  = 6;
   localparam int BIT_CMP_EN  = 5;
   localparam int BIT_CMP_GT  = 4;
   localparam int CH_W        = 5;
   localparam int PINS        = 24;
   localparam logic [4:0] CH_OFF       = 5'h1f;
   localparam logic [4:0] CH_RESET     = 5'h1f;
   localparam logic [7:0] CFG_RESET    = 8'h00;
   localparam logic [7:0] PIN_RESET    = 8'h00;
   localparam logic [1:0] MODE_8BIT    = 2'h0;
   localparam logic [1:0] MODE_10BIT   = 2'h2;
   localparam logic [9:0] FULL_SCALE10 = 10'h3ff;
   localparam logic [7:0] FULL_SCALE8  = 8'hff;
   // converter clock sources
   typedef enum logic [1:0] {
      SRC_BUS   = 2'b00,
      SRC_HALF  = 2'b01,
      SRC_ALT   = 2'b10,
      SRC_ASYNC = 2'b11
   } apc_src_e;
   // configuration register layout, bit 7 down to 0
   typedef struct packed {
      logic       low_power;
      logic [1:0] divide;
      logic       long_sample;
      logic [1:0] mode;
      apc_src_e   source;
   } apc_cfg_s;
   // answer from the converter core
   typedef struct packed {
      logic        done;
      logic [10:0] result;
   } apc_sar_s;
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } apc_state_e;
endpackage

// ### hw/apc_clkdiv.sv
// source select and power-of-two divider for the converter clock
module apc_clkdiv
   import apc_pkg::*;
#(
   parameter int ASYNC_PERIOD = 4
) (
   input  wire logic     clk,
   input  wire logic     nrst,
   input  wire logic     run,
   input  wire apc_src_e source,
   input  wire logic [1:0] divide,
   input  wire logic     alt_tick,
   output logic          conv_tick
);
   logic       half_reg;
   logic [7:0] async_cnt_reg;
   logic [2:0] div_cnt_reg;
   logic       conv_tick_reg;
   wire        async_tick = (async_cnt_reg == 8'(ASYNC_PERIOD - 1));
   wire        src_tick   = (source == SRC_BUS)  ? 1'b1     :
                            (source == SRC_HALF) ? half_reg :
                            (source == SRC_ALT)  ? alt_tick : async_tick;
   // divide mask 0,1,3,7 gives ratios 1,2,4,8
   wire [2:0]  div_mask   = 3'((4'h1 << divide) - 4'h1);
   wire        div_hit    = src_tick && ((div_cnt_reg & div_mask) == div_mask);

   // counters only move while the converter is awake, saving power when idle
   always_ff @(posedge clk) begin
      if (!nrst || !run) begin
         half_reg      <= 1'b0;
         async_cnt_reg <= 8'h00;
         div_cnt_reg   <= 3'h0;
         conv_tick_reg <= 1'b0;
      end else begin
         half_reg      <= !half_reg;
         async_cnt_reg <= async_tick ? 8'h00 : async_cnt_reg + 8'h01;
         div_cnt_reg   <= div_hit ? 3'h0 : (src_tick ? div_cnt_reg + 3'h1 : div_cnt_reg);
         conv_tick_reg <= div_hit;
      end
   end
   assign conv_tick = conv_tick_reg;
endmodule // apc_clkdiv

// ### hw/apc_ctrl.sv
// converter control slice: registers, result placement, clocking
//
// Implementation choices: the register offsets and register access over AHB-Lite.
module apc_ctrl
   import apc_pkg::*;
#(
   parameter int ASYNC_PERIOD = 4
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire apc_sar_s           sar_in,
   input  wire logic               alt_tick,
   input  wire logic               stop_mode,
   output logic [PINS-1:0]         pin_release,
   output logic                    module_enable,
   output logic                    conv_active,
   output logic                    sar_start,
   output logic                    conv_tick,
   output logic                    async_osc_en,
   output logic [CH_W-1:0]         channel_select,
   output apc_cfg_s                cfg_out,
   output logic                    irq
);
   logic [CH_W-1:0] channel_reg;
   logic            irq_en_reg;
   logic            done_reg;
   logic            cmp_en_reg;
   logic            cmp_gt_reg;
   logic [1:0]      res_hi_reg;
   logic [7:0]      res_lo_reg;
   logic [1:0]      cmp_hi_reg;
   logic [7:0]      cmp_lo_reg;
   apc_cfg_s        cfg_reg;
   logic [7:0]      pin_lo_reg;
   logic [7:0]      pin_mid_reg;
   logic [7:0]      pin_hi_reg;
   logic            lock_reg;
   apc_state_e      state_reg;
   apc_state_e      state_next;
   logic            start_reg;
   logic [31:0]     hrdata_reg;
   logic            wr_pend_reg;
   logic [7:0]      wr_addr_reg;
   logic            irq_reg;
   logic            async_en_reg;
   logic            tick_w;

   // address phase decode
   wire        take    = hsel && hready && htrans[1];
   wire        rd_take = take && !hwrite;
   wire [7:0]  ofs     = haddr[7:0];
   wire        rd_hi   = rd_take && (ofs == OFS_RES_HI);
   wire        rd_lo   = rd_take && (ofs == OFS_RES_LO);

   // data phase write strobes
   wire        wr_ctrl   = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
   wire        wr_cmpctl = wr_pend_reg && (wr_addr_reg == OFS_CMPCTL);
   wire        wr_cmp_hi = wr_pend_reg && (wr_addr_reg == OFS_CMP_HI);
   wire        wr_cmp_lo = wr_pend_reg && (wr_addr_reg == OFS_CMP_LO);
   wire        wr_cfg    = wr_pend_reg && (wr_addr_reg == OFS_CFG);
   wire        wr_p_lo   = wr_pend_reg && (wr_addr_reg == OFS_PIN_LO);
   wire        wr_p_mid  = wr_pend_reg && (wr_addr_reg == OFS_PIN_MID);
   wire        wr_p_hi   = wr_pend_reg && (wr_addr_reg == OFS_PIN_HI);
   // a change of setup makes the running conversion worthless
   wire        abort_w   = wr_cmpctl || wr_cmp_hi || wr_cmp_lo || wr_cfg ||
                           (stop_mode && cfg_reg.source != SRC_ASYNC);
   wire [CH_W-1:0] ch_new = hwdata[CH_W-1:0];
   wire        ch_off    = (channel_reg == CH_OFF);

   // rounding of the raw approximation result
   wire [10:0] rnd10  = {1'b0, sar_in.result[10:1]} + 11'(sar_in.result[0]);
   wire [9:0]  val10  = rnd10[10] ? FULL_SCALE10 : rnd10[9:0];
   wire [8:0]  rnd8   = {1'b0, sar_in.result[8:1]} + 9'(sar_in.result[0]);
   wire [7:0]  val8   = rnd8[8] ? FULL_SCALE8 : rnd8[7:0];
   wire        is10   = (cfg_reg.mode == MODE_10BIT);
   wire [9:0]  res_val = is10 ? val10 : {2'b00, val8};
   wire [9:0]  cmp_val = is10 ? {cmp_hi_reg, cmp_lo_reg} : {2'b00, cmp_lo_reg};
   // compare gate: with compare enabled, update only when the condition holds
   wire        cmp_met = cmp_gt_reg ? (res_val >= cmp_val) : (res_val < cmp_val);
   wire        cmp_ok  = !cmp_en_reg || cmp_met;
   wire        finish  = (state_reg == ST_CONV) && sar_in.done && !abort_w && !wr_ctrl;
   wire        blocked = lock_reg && is10;
   wire        store   = finish && cmp_ok && !blocked;
   // a blocked result is dropped and another conversion is launched
   wire        retry   = finish && blocked;
   wire        launch  = (wr_ctrl && ch_new != CH_OFF) || retry;

   // register read mux, unmapped offsets read zero
   wire [31:0] rd_mux =
      (ofs == OFS_CTRL)    ? 32'({done_reg, irq_en_reg, 1'b0, channel_reg}) :
      (ofs == OFS_CMPCTL)  ? 32'({cmp_en_reg, cmp_gt_reg, 4'h0}) :
      (ofs == OFS_RES_HI)  ? 32'(res_hi_reg) :
      (ofs == OFS_RES_LO)  ? 32'(res_lo_reg) :
      (ofs == OFS_CMP_HI)  ? 32'(cmp_hi_reg) :
      (ofs == OFS_CMP_LO)  ? 32'(cmp_lo_reg) :
      (ofs == OFS_CFG)     ? 32'(cfg_reg) :
      (ofs == OFS_PIN_LO)  ? 32'(pin_lo_reg) :
      (ofs == OFS_PIN_MID) ? 32'(pin_mid_reg) :
      (ofs == OFS_PIN_HI)  ? 32'(pin_hi_reg) : 32'h0000_0000;

   // bus slave: zero wait states, read data registered for the data phase
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= take && hwrite;
         wr_addr_reg <= ofs;
         if (rd_take) begin
            hrdata_reg <= rd_mux;
         end
      end
   end

   // control, compare and clock setup
   always_ff @(posedge clk) begin
      if (!nrst) begin
         channel_reg <= CH_RESET;
         irq_en_reg  <= 1'b0;
         cmp_en_reg  <= 1'b0;
         cmp_gt_reg  <= 1'b0;
         cmp_hi_reg  <= 2'h0;
         cmp_lo_reg  <= 8'h00;
         cfg_reg     <= apc_cfg_s'(CFG_RESET);
      end else begin
         if (wr_ctrl) begin
            channel_reg <= ch_new;
            irq_en_reg  <= hwdata[BIT_IRQ_EN];
         end
         if (wr_cmpctl) begin
            cmp_en_reg <= hwdata[BIT_CMP_EN];
            cmp_gt_reg <= hwdata[BIT_CMP_GT];
         end
         if (wr_cmp_hi) begin
            cmp_hi_reg <= hwdata[1:0];
         end
         if (wr_cmp_lo) begin
            cmp_lo_reg <= hwdata[7:0];
         end
         if (wr_cfg) begin
            cfg_reg <= apc_cfg_s'(hwdata[7:0]);
         end
      end
   end

   // pin release registers, one bit per channel pin
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_lo_reg  <= PIN_RESET;
         pin_mid_reg <= PIN_RESET;
         pin_hi_reg  <= PIN_RESET;
      end else begin
         if (wr_p_lo) begin
            pin_lo_reg <= hwdata[7:0];
         end
         if (wr_p_mid) begin
            pin_mid_reg <= hwdata[7:0];
         end
         if (wr_p_hi) begin
            pin_hi_reg <= hwdata[7:0];
         end
      end
   end

   // results, done flag and read interlock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         res_hi_reg <= 2'h0;
         res_lo_reg <= 8'h00;
         done_reg   <= 1'b0;
         lock_reg   <= 1'b0;
      end else begin
         if (store) begin
            res_hi_reg <= res_val[9:8];
            res_lo_reg <= res_val[7:0];
         end
         // a new result wins over the clearing low read; a control write drops the result
         if (store) begin
            done_reg <= 1'b1;
         end else if (rd_lo || wr_ctrl) begin
            done_reg <= 1'b0;
         end
         // the low read releases the lock taken by a high read
         if (rd_lo) begin
            lock_reg <= 1'b0;
         end else if (rd_hi && is10) begin
            lock_reg <= 1'b1;
         end
      end
   end

   // conversion sequencer: off, idle, converting
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (launch) begin
               state_next = ST_CONV;
            end
         end
         ST_IDLE: begin
            if (wr_ctrl && ch_new == CH_OFF) begin
               state_next = ST_OFF;
            end else if (launch) begin
               state_next = ST_CONV;
            end
         end
         ST_CONV: begin
            if (wr_ctrl && ch_new == CH_OFF) begin
               state_next = ST_OFF;
            end else if (launch) begin
               state_next = ST_CONV;
            end else if (finish || abort_w) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   // state, start pulse, interrupt and async oscillator request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg    <= ST_OFF;
         start_reg    <= 1'b0;
         irq_reg      <= 1'b0;
         async_en_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         start_reg    <= launch;
         irq_reg      <= irq_en_reg && (done_reg || store);
         // async source keeps running in wait and stop while busy
         async_en_reg <= (state_next == ST_CONV) && (cfg_reg.source == SRC_ASYNC);
      end
   end

   // converter clock only runs while a conversion is in flight
   apc_clkdiv #(
      .ASYNC_PERIOD (ASYNC_PERIOD)
   ) u_clkdiv (
      .clk       (clk),
      .nrst      (nrst),
      .run       (state_reg == ST_CONV),
      .source    (cfg_reg.source),
      .divide    (cfg_reg.divide),
      .alt_tick  (alt_tick),
      .conv_tick (tick_w)
   );

   // outputs come from flip-flops or state decodes, hreadyout and hresp are tied off
   assign pin_release    = {pin_hi_reg, pin_mid_reg, pin_lo_reg};
   assign module_enable  = (state_reg != ST_OFF);
   assign conv_active    = (state_reg == ST_CONV);
   assign sar_start      = start_reg;
   assign conv_tick      = tick_w;
   assign async_osc_en   = async_en_reg;
   assign channel_select = channel_reg;
   assign cfg_out        = cfg_reg;
   assign irq            = irq_reg;
   assign hrdata         = hrdata_reg;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_high_read;
      rd_hi && is10;
   endsequence
   sequence s_result_arrives;
      finish && lock_reg && is10;
   endsequence

   // a high read arms the interlock on the next edge
   property p_lock_taken;
      s_high_read |=> lock_reg;
   endproperty
   a_lock_taken: assert property (p_lock_taken)
      else $error("high read did not arm the interlock");

   // a result landing while armed leaves registers and flag alone
   property p_block_result;
      s_result_arrives |=> $stable(res_lo_reg) && $stable(res_hi_reg) && !$rose(done_reg);
   endproperty
   a_block_result: assert property (p_block_result)
      else $error("result replaced while interlocked");

   property p_done_set;
      store |=> done_reg && res_lo_reg == $past(res_val[7:0]);
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag or low result wrong after store");

   property p_irq;
      (store && irq_en_reg) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt missing after result");

   property p_off;
      ch_off && !launch |=> !module_enable || $past(state_reg) != ST_OFF;
   endproperty
   a_off: assert property (p_off)
      else $error("module enabled with channel all ones");

   property p_cmp_gate;
      (finish && cmp_en_reg && !cmp_met) |=> $stable(res_lo_reg) && $stable(res_hi_reg);
   endproperty
   a_cmp_gate: assert property (p_cmp_gate)
      else $error("result stored with compare false");

   property p_idle_clock;
      (state_reg != ST_CONV) ##1 (state_reg != ST_CONV) |-> !conv_tick;
   endproperty
   a_idle_clock: assert property (p_idle_clock)
      else $error("converter clock running while idle");

   property p_eight_bit_high;
      (store && !is10) |=> res_hi_reg == 2'h0;
   endproperty
   a_eight_bit_high: assert property (p_eight_bit_high)
      else $error("8-bit result touched high register");

   property p_bus_tick;
      (conv_active && cfg_reg.source == SRC_BUS && cfg_reg.divide == 2'h0)[*3]
         |-> conv_tick;
   endproperty
   a_bus_tick: assert property (p_bus_tick)
      else $error("bus clock divide by one not ticking every cycle");

   property p_pins;
      wr_p_mid |=> pin_release[15:8] == $past(hwdata[7:0]);
   endproperty
   a_pins: assert property (p_pins)
      else $error("mid pin register not applied");
endmodule // apc_ctrl

// ### verif/apc_sar_model.sv
// behavioural converter core: answers after a set number of converter ticks
module apc_sar_model
   import apc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        sar_start,
   input  wire logic        conv_active,
   input  wire logic        conv_tick,
   input  wire logic [7:0]  ticks,
   input  wire logic [10:0] value,
   output apc_sar_s         sar_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       busy;
   logic       act_q;
   logic [7:0] cnt;
   // result lines flip every cycle outside an answer, so stale data never looks valid
   always_ff @(posedge clk) begin
      if (!nrst) begin
         busy   <= 1'b0;
         act_q  <= 1'b0;
         cnt    <= 8'h00;
         sar_in <= '0;
      end else begin
         act_q         <= conv_active;
         sar_in.done   <= 1'b0;
         sar_in.result <= ~sar_in.result;
         if (sar_start) begin
            busy <= 1'b1;
            cnt  <= 8'h00;
         end else if (busy && act_q && !conv_active) begin
            busy <= 1'b0; // aborted by the controller
         end else if (busy && conv_tick) begin
            cnt <= cnt + 8'h01;
            if (cnt == ticks - 8'h01) begin
               busy          <= 1'b0;
               sar_in.done   <= 1'b1;
               sar_in.result <= value;
            end
         end
      end
   end
endmodule // apc_sar_model

// ### verif/test_adc_pin_and_clock_control.sv
// self-checking bench for the converter control slice
module test_adc_pin_and_clock_control
   import apc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AP = 4;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, alt_tick = 1'b0, stop_mode = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'h2;
   logic        hready, hreadyout, hresp, module_enable, conv_active, sar_start;
   logic        conv_tick, async_osc_en, irq;
   logic [PINS-1:0] pin_release;
   logic [CH_W-1:0] channel_select;
   apc_cfg_s    cfg_out;
   apc_sar_s    sar_in;
   logic [10:0] value = '0;
   logic [9:0]  exp_res = '0;
   logic [23:0] exp_pins = '0;
   logic        last_ten = 1'bx;
   int          error_cnt = 0, checked = 0, cyc = 0, alt_cnt = 0;
   assign hready = hreadyout;
   apc_ctrl #(.ASYNC_PERIOD(AP)) u_apc_ctrl (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sar_in(sar_in),
      .alt_tick(alt_tick), .stop_mode(stop_mode), .pin_release(pin_release),
      .module_enable(module_enable), .conv_active(conv_active), .sar_start(sar_start),
      .conv_tick(conv_tick), .async_osc_en(async_osc_en), .channel_select(channel_select),
      .cfg_out(cfg_out), .irq(irq));
   apc_sar_model u_apc_sar_model (.clk(clk), .nrst(nrst), .sar_start(sar_start),
      .conv_active(conv_active), .conv_tick(conv_tick), .ticks(8'h08), .value(value),
      .sar_in(sar_in));
   // clock, alternate source every third cycle, and a hang limit
   always #20 clk = ~clk;
   always @(posedge clk) begin
      alt_cnt  <= (alt_cnt == 2) ? 0 : alt_cnt + 1;
      alt_tick <= (alt_cnt == 2);
      cyc      <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // one single ahb transfer; the master waits on hready at every phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, e, m);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sar_in.done !== 1'b1 && n < 3000);
      if (n >= 3000) chk(32'h0, 32'h1, "no answer");
   endtask
   // rounding with saturation at full scale of the chosen width
   function automatic logic [9:0] round_res(input logic [10:0] v, input logic ten);
      logic [10:0] s;
      s = ten ? ({1'b0, v[10:1]} + 11'(v[0])) : ({3'h0, v[8:1]} + 11'(v[0]));
      if (ten) return (s > 11'h3ff) ? 10'h3ff : s[9:0];
      return (s > 11'h0ff) ? 10'h0ff : s[9:0];
   endfunction
   // one single conversion, compare value fixed at 280 / 80
   task automatic run_conv(input logic ten, input logic ce, input logic gt, input logic [10:0] v);
      logic [9:0] r;
      logic       upd;
      r   = round_res(v, ten);
      upd = !ce || (gt ? (r >= (ten ? 10'h280 : 10'h080)) : (r < (ten ? 10'h280 : 10'h080)));
      wr(OFS_CMPCTL, {26'h0, ce, gt, 4'h0});
      wr(OFS_CFG, {25'h0, 2'b10, 1'b0, ten ? MODE_10BIT : MODE_8BIT, 2'b00});
      value <= v;
      wr(OFS_CTRL, 32'h45);
      wait_done();
      repeat (2) @(posedge clk);
      chk(32'(module_enable), 32'h1, "enable");
      chk(32'(channel_select), 32'h05, "channel");
      chk(32'(conv_active), 32'h0, "idle");
      chk(32'(irq), 32'(upd), "irq");
      rchk(OFS_CTRL, {24'h0, upd, 7'h45}, "done flag");
      if (upd) exp_res = r;
      if (upd || ten === last_ten) begin
         rchk(OFS_RES_HI, {30'h0, exp_res[9:8]}, "res hi");
         rchk(OFS_RES_LO, {24'h0, exp_res[7:0]}, "res lo");
         repeat (2) @(posedge clk);
         chk(32'(irq), 32'h0, "irq clear");
      end
      last_ten = ten;
   endtask
   // main sequence
   initial begin
      logic [7:0] pv;
      int         g, eg;
      void'($urandom(91484));
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk(32'(pin_release), 32'h0, "pin reset");
      chk(32'(module_enable), 32'h0, "off at reset");
      chk(32'(cfg_out.source), 32'(SRC_BUS), "source reset");
      rchk(OFS_CTRL, 32'h1f, "ctrl reset");
      for (int r = 0; r < 3; r++) begin
         rchk(OFS_PIN_LO + 8'(4 * r), 32'h0, "pin reg reset");
      end
      rchk(8'h40, 32'h0, "unmapped");
      $display("test reset done");
      // every pin register, a random value and two boundary patterns
      for (int r = 0; r < 3; r++) for (int k = 0; k < 3; k++) begin
         pv = (k == 0) ? 8'($urandom) : ((k == 1) ? 8'h81 : 8'h7e);
         exp_pins[8 * r +: 8] = pv;
         wr(OFS_PIN_LO + 8'(4 * r), {24'($urandom), pv});
         rchk(OFS_PIN_LO + 8'(4 * r), {24'h0, pv}, "pin reg");
         chk(32'(pin_release), 32'(exp_pins), "pins");
      end
      $display("test pins done");
      // every source and divide code, gap between converter ticks
      for (int s = 0; s < 4; s++) for (int d = 0; d < 4; d++) begin
         wr(OFS_CFG, {25'h0, 2'(d), 1'b0, MODE_10BIT, 2'(s)});
         wr(OFS_CTRL, 32'h01);
         g = 0;
         do @(posedge clk); while (conv_tick !== 1'b1 && ++g < 500);
         g = 0;
         do begin
            @(posedge clk);
            g++;
         end while (conv_tick !== 1'b1 && g < 500);
         eg = ((s == 3) ? AP : s + 1) << d;
         chk(32'(g), 32'(eg), "tick gap");
      end
      $display("test clock done");
      // stop: async source keeps converting, bus source is aborted
      wr(OFS_CFG, {25'h0, 2'b10, 1'b0, MODE_10BIT, SRC_ASYNC});
      wr(OFS_CTRL, 32'h45);
      stop_mode <= 1'b1;
      repeat (10) @(posedge clk);
      chk(32'(conv_active), 32'h1, "async in stop");
      chk(32'(async_osc_en), 32'h1, "async osc");
      stop_mode <= 1'b0;
      wr(OFS_CFG, {25'h0, 2'b10, 1'b0, MODE_10BIT, SRC_BUS});
      wr(OFS_CTRL, 32'h45);
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(conv_active), 32'h0, "bus in stop");
      stop_mode <= 1'b0;
      wr(OFS_CTRL, 32'h1f);
      repeat (2) @(posedge clk);
      chk(32'(module_enable), 32'h0, "channel off");
      chk(32'(channel_select), 32'h1f, "channel field off");
      chk(32'(conv_active), 32'h0, "no start when off");
      $display("test stop done");
      // conversions, full-scale corners first, then random modes and compares
      wr(OFS_CMP_HI, 32'h2);
      wr(OFS_CMP_LO, 32'h80);
      run_conv(1'b1, 1'b0, 1'b0, 11'h7ff);
      run_conv(1'b0, 1'b0, 1'b0, 11'h1ff);
      for (int i = 0; i < 12; i++) begin
         run_conv(1'($urandom), 1'($urandom), 1'($urandom), 11'($urandom));
      end
      run_conv(1'b1, 1'b0, 1'b0, 11'($urandom));
      $display("test conversion done");
      // high read locks out the next result until low is read
      rchk(OFS_RES_HI, {30'h0, exp_res[9:8]}, "lock hi");
      value <= 11'($urandom);
      wr(OFS_CTRL, 32'h45);
      wait_done();
      repeat (2) @(posedge clk);
      chk(32'(conv_active), 32'h1, "restart after drop");
      rchk(OFS_CTRL, 32'h45, "blocked done");
      value <= 11'h555;
      rchk(OFS_RES_LO, {24'h0, exp_res[7:0]}, "old lo");
      wait_done();
      repeat (2) @(posedge clk);
      exp_res = round_res(11'h555, 1'b1);
      rchk(OFS_RES_HI, {30'h0, exp_res[9:8]}, "new hi");
      rchk(OFS_RES_LO, {24'h0, exp_res[7:0]}, "new lo");
      $display("test lock done");
      final_report();
   end
endmodule // test_adc_pin_and_clock_control
